// file: shared/wide_decode_pkg.sv
package wide_decode_pkg;

	typedef enum logic [1:0] {
		mode_legacy,
		mode_compat,
		mode_wide
	} cpu_mode_t;

	typedef enum logic [1:0] {
		size_16,
		size_32,
		size_64
	} width_t;

	typedef enum logic [2:0] {
		seg_none,
		seg_extra_one,
		seg_extra_two,
		seg_legacy
	} seg_sel_t;

	// Prefix and opcode bytes
	localparam logic [7:0] pfx_opsize       = 8'h66;
	localparam logic [7:0] pfx_addrsize     = 8'h67;
	localparam logic [7:0] pfx_seg_code     = 8'h2e;
	localparam logic [7:0] pfx_seg_stack    = 8'h36;
	localparam logic [7:0] pfx_seg_data     = 8'h3e;
	localparam logic [7:0] pfx_seg_xdata    = 8'h26;
	localparam logic [7:0] pfx_seg_one      = 8'h64;
	localparam logic [7:0] pfx_seg_two      = 8'h65;
	localparam logic [7:0] pfx_ext_base     = 8'h40;
	localparam logic [7:0] pfx_ext_mask     = 8'hf0;
	localparam int         ext_w_bit        = 3;
	localparam logic [7:0] op_escape        = 8'h0f;
	localparam logic [7:0] op_nop           = 8'h90;
	localparam logic [7:0] op_exchange_op_rm       = 8'h87;
	localparam logic [7:0] op_enter         = 8'hc8;
	localparam logic [7:0] op_leave         = 8'hc9;
	localparam logic [7:0] op_pop_rm        = 8'h8f;
	localparam logic [7:0] op_pop_reg       = 8'h58;
	localparam logic [7:0] op_push_reg      = 8'h50;
	localparam logic [7:0] op_reg_mask      = 8'hf8;
	localparam logic [7:0] op_popf          = 8'h9d;
	localparam logic [7:0] op_pushf         = 8'h9c;
	localparam logic [7:0] op_push_imm32    = 8'h68;
	localparam logic [7:0] op_push_imm8     = 8'h6a;
	localparam logic [7:0] op_grp5          = 8'hff;
	localparam logic [7:0] op_call_rel      = 8'he8;
	localparam logic [7:0] op_jmp_rel       = 8'he9;
	localparam logic [7:0] op_jmp_short     = 8'heb;
	localparam logic [7:0] op_loop          = 8'he2;
	localparam logic [7:0] op_loopne        = 8'he0;
	localparam logic [7:0] op_loope         = 8'he1;
	localparam logic [7:0] op_ret           = 8'hc3;
	localparam logic [7:0] op_ret_imm       = 8'hc2;
	localparam logic [7:0] op_jcc_short     = 8'h70;
	localparam logic [7:0] op_jcc_mask      = 8'hf0;
	localparam logic [7:0] op_call_far      = 8'h9a;
	localparam logic [7:0] op_jmp_far       = 8'hea;
	localparam logic [7:0] op_mov_moffs_lo  = 8'ha0;
	localparam logic [7:0] op_mov_moffs_msk = 8'hfc;
	localparam logic [7:0] op_mov_imm_reg   = 8'hb8;
	// Second bytes after escape
	localparam logic [7:0] op2_push_one     = 8'ha0;
	localparam logic [7:0] op2_pop_one      = 8'ha1;
	localparam logic [7:0] op2_push_two     = 8'ha8;
	localparam logic [7:0] op2_pop_two      = 8'ha9;
	localparam logic [7:0] op2_fast_entry   = 8'h34;
	localparam logic [7:0] op2_fast_exit    = 8'h35;
	localparam logic [7:0] op2_sys_group    = 8'h01;
	localparam logic [7:0] op2_kswap_modrm  = 8'hf8;
	localparam logic [7:0] op2_jcc_near     = 8'h80;
	// ModRM fields
	localparam int         modrm_reg_lsb    = 3;
	localparam logic [2:0] grp5_call_ind    = 3'd2;
	localparam logic [2:0] grp5_call_far    = 3'd3;
	localparam logic [2:0] grp5_jmp_ind     = 3'd4;
	localparam logic [2:0] grp5_jmp_far     = 3'd5;
	localparam logic [2:0] grp5_push        = 3'd6;
	localparam logic [1:0] modrm_mod_direct = 2'b00;
	localparam logic [2:0] modrm_rm_disp    = 3'b101;
	// Privilege
	localparam logic [1:0] priv_user        = 2'd3;
	// Gate and segment checks
	localparam logic [3:0] gate_type_call64 = 4'hc;
	localparam logic [3:0] gate_type_task   = 4'h5;
	localparam logic [15:0] null_selector   = 16'h0000;
	localparam logic [15:0] sel_rpl_clear   = 16'hfffc;
	// Result merging widths and prefix count limit
	localparam int         byte_bits        = 8;
	localparam int         half_bits        = 16;
	localparam int         word_bits        = 32;
	localparam int         max_prefixes     = 4;

endpackage

// file: hw/wide_dest_merge.sv
`timescale 1ns/1ps
module wide_dest_merge
	import wide_decode_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        in_valid,
	input  wire logic [1:0]  in_width,
	input  wire logic        in_byte,
	input  wire logic [63:0] in_old,
	input  wire logic [63:0] in_result,
	output logic             out_valid,
	output logic [63:0]      out_value
);

	logic [63:0] next_value;

	always_comb begin
		next_value = in_old;
		if (in_byte) begin
			next_value[byte_bits-1:0] = in_result[byte_bits-1:0];
		end else if (in_width == 2'(size_16)) begin
			next_value[half_bits-1:0] = in_result[half_bits-1:0];
		end else if (in_width == 2'(size_32)) begin
			next_value = {32'h0000_0000, in_result[word_bits-1:0]};
		end else begin
			next_value = in_result;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_value <= 64'h0;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				out_value <= next_value;
			end
		end
	end

endmodule

// file: hw/wide_mode_prefix_size_decode.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Meaningless extension prefix is ignored
// - Operand 32 default, 66h 16, W wins
// - Data, xdata, stack, code overrides are null
// - Extra segment overrides add their base
// - 32-bit register writes zero extend
// - 8/16-bit writes keep upper bits
// - Address 64 default, 67h 32, no 16
// - Displacement and immediate sign extend from 32, except wide moffs displacement and W mov-imm immediate
// - Address truncated to size then zero extended
// - Pointer-relative adds next instruction pointer
// - Stack ops default 64, 16 allowed only
// - Near branches default 64 operand size
// - Near address 64, 32 by prefix
// - Far gate must be 64-bit call gate
// - Gate stack switch loads null selector
// - Far return null selector needs level<3
// - Task gates fault in long mode
// - Direct far branches invalid in wide mode
// - Kernel base swap only in wide mode
// - Fast entry and exit fault in long
// - Opcode 90h is a true no-operation
// - Two-byte self exchange still executes
module wide_mode_prefix_size_decode
	import wide_decode_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [1:0]  cpu_mode,
	input  wire logic [1:0]  cur_priv,
	input  wire logic        legacy_op32,
	input  wire logic        legacy_addr32,
	input  wire logic [31:0] prefix_bytes,
	input  wire logic [2:0]  prefix_count,
	input  wire logic        ext_present,
	input  wire logic [3:0]  ext_bits,
	input  wire logic [7:0]  opcode,
	input  wire logic [7:0]  opcode2,
	input  wire logic [7:0]  modrm,
	input  wire logic [63:0] disp,
	input  wire logic [63:0] imm,
	input  wire logic [63:0] next_ip,
	input  wire logic [63:0] base_value,
	input  wire logic [63:0] index_value,
	input  wire logic [63:0] seg_one_base,
	input  wire logic [63:0] seg_two_base,
	input  wire logic        gate_access,
	input  wire logic        far_return,
	input  wire logic [3:0]  gate_type,
	input  wire logic        gate_target_wide,
	input  wire logic [63:0] gate_offset,
	input  wire logic        gate_priv_change,
	input  wire logic [1:0]  gate_new_priv,
	input  wire logic [63:0] table_stack_ptr,
	input  wire logic [15:0] ret_stack_sel,
	input  wire logic        ret_target_wide,
	input  wire logic [1:0]  ret_target_priv,
	input  wire logic        wb_valid,
	input  wire logic        wb_byte,
	input  wire logic [1:0]  wb_width,
	input  wire logic [63:0] wb_old,
	input  wire logic [63:0] wb_result,
	output logic             wb_out_valid,
	output logic [63:0]      wb_out_value,
	input  wire logic        out_ready,
	output logic             out_valid,
	output logic [1:0]       op_width,
	output logic [1:0]       addr_width,
	output logic [2:0]       seg_sel,
	output logic [63:0]      eff_addr,
	output logic [63:0]      imm_ext,
	output logic             is_nop,
	output logic             is_stack_op,
	output logic             is_near_branch,
	output logic             invalid_op_fault,
	output logic             protect_fault,
	output logic [63:0]      branch_target,
	output logic             load_stack_ptr,
	output logic [63:0]      new_stack_ptr,
	output logic             load_stack_sel,
	output logic [15:0]      new_stack_sel,
	output logic             push_wide,
	output logic             copy_params
);

	function automatic logic in_prefixes(input logic [31:0] bytes,
		input logic [2:0] count, input logic [7:0] value);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < max_prefixes; i++) begin
			if (3'(i) < count && bytes[i*8 +: 8] == value) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	function automatic logic reg_form(input logic [7:0] op,
		input logic [7:0] base);
		return (op & op_reg_mask) == base;
	endfunction

	logic        wide;
	logic        long_mode;
	logic        has_opsz;
	logic        has_adsz;
	logic        ext_w;
	logic [2:0]  mreg;
	logic        stack_op;
	logic        near_br;
	logic        direct_far;
	logic        far_ind;
	logic        moffs_form;
	logic        ip_rel;
	logic        nop_form;
	logic        fault_ud;
	logic        fault_gp;
	logic [1:0]  next_opw;
	logic [1:0]  next_adw;
	logic [2:0]  next_seg;
	logic [63:0] disp_ext;
	logic [63:0] raw_addr;
	logic [63:0] seg_add;
	logic [63:0] next_addr;
	logic [63:0] next_imm;
	logic        take;

	assign wide      = cpu_mode == 2'(mode_wide);
	assign long_mode = wide || cpu_mode == 2'(mode_compat);
	assign has_opsz  = in_prefixes(prefix_bytes, prefix_count, pfx_opsize);
	assign has_adsz  = in_prefixes(prefix_bytes, prefix_count, pfx_addrsize);
	assign ext_w     = wide && ext_present && ext_bits[ext_w_bit];
	assign mreg      = modrm[modrm_reg_lsb +: 3];
	assign take      = in_valid && in_ready;
	assign in_ready  = !out_valid || out_ready;

	always_comb begin
		stack_op = 1'b0;
		near_br  = 1'b0;
		if (opcode == op_escape) begin
			stack_op = opcode2 == op2_push_one || opcode2 == op2_pop_one ||
				opcode2 == op2_push_two || opcode2 == op2_pop_two;
			near_br = (opcode2 & op_jcc_mask) == op2_jcc_near;
		end else begin
			stack_op = opcode == op_enter || opcode == op_leave ||
				opcode == op_pop_rm || opcode == op_popf ||
				opcode == op_pushf || opcode == op_push_imm32 ||
				opcode == op_push_imm8 || reg_form(opcode, op_pop_reg) ||
				reg_form(opcode, op_push_reg) ||
				(opcode == op_grp5 && mreg == grp5_push);
			near_br = opcode == op_call_rel || opcode == op_jmp_rel ||
				opcode == op_jmp_short || opcode == op_loop ||
				opcode == op_loope || opcode == op_loopne ||
				opcode == op_ret || opcode == op_ret_imm ||
				(opcode & op_jcc_mask) == op_jcc_short ||
				(opcode == op_grp5 &&
				(mreg == grp5_call_ind || mreg == grp5_jmp_ind));
		end
	end

	assign direct_far = opcode == op_call_far || opcode == op_jmp_far;
	assign far_ind    = opcode == op_grp5 &&
		(mreg == grp5_call_far || mreg == grp5_jmp_far);
	assign moffs_form = (opcode & op_mov_moffs_msk) == op_mov_moffs_lo;
	assign ip_rel     = wide && modrm[7:6] == modrm_mod_direct &&
		modrm[2:0] == modrm_rm_disp && opcode != op_escape;
	// One-byte 90h only; 87h not matched
	assign nop_form   = wide && opcode == op_nop;

	always_comb begin
		if (!wide) begin
			next_opw = (legacy_op32 ^ has_opsz) ? 2'(size_32) : 2'(size_16);
		end else if (stack_op || near_br) begin
			next_opw = (has_opsz && !ext_w) ? 2'(size_16) : 2'(size_64);
		end else if (ext_w) begin
			next_opw = 2'(size_64);
		end else begin
			next_opw = has_opsz ? 2'(size_16) : 2'(size_32);
		end
	end

	always_comb begin
		if (wide) begin
			next_adw = has_adsz ? 2'(size_32) : 2'(size_64);
		end else begin
			next_adw = (legacy_addr32 ^ has_adsz) ? 2'(size_32) : 2'(size_16);
		end
	end

	always_comb begin
		next_seg = 3'(seg_none);
		for (int i = 0; i < max_prefixes; i++) begin
			if (3'(i) < prefix_count) begin
				if (prefix_bytes[i*8 +: 8] == pfx_seg_one) begin
					next_seg = 3'(seg_extra_one);
				end else if (prefix_bytes[i*8 +: 8] == pfx_seg_two) begin
					next_seg = 3'(seg_extra_two);
				end else if (!wide && (prefix_bytes[i*8 +: 8] == pfx_seg_code ||
					prefix_bytes[i*8 +: 8] == pfx_seg_stack ||
					prefix_bytes[i*8 +: 8] == pfx_seg_data ||
					prefix_bytes[i*8 +: 8] == pfx_seg_xdata)) begin
					next_seg = 3'(seg_legacy);
				end
			end
		end
	end

	always_comb begin
		disp_ext = (wide && moffs_form && !has_adsz) ? disp :
			{{32{disp[31]}}, disp[31:0]};
		next_imm = (wide && ext_w && reg_form(opcode, op_mov_imm_reg)) ?
			imm : {{32{imm[31]}}, imm[31:0]};
		raw_addr = ip_rel ? next_ip + disp_ext :
			base_value + index_value + disp_ext;
		seg_add = 64'h0;
		if (next_seg == 3'(seg_extra_one)) begin
			seg_add = wide ? seg_one_base : {32'h0, seg_one_base[31:0]};
		end else if (next_seg == 3'(seg_extra_two)) begin
			seg_add = wide ? seg_two_base : {32'h0, seg_two_base[31:0]};
		end
		unique case (next_adw)
			2'(size_16): next_addr = {48'h0, raw_addr[15:0]};
			2'(size_32): next_addr = {32'h0, raw_addr[31:0]};
			default:     next_addr = raw_addr;
		endcase
		next_addr = next_addr + seg_add;
	end

	always_comb begin
		fault_ud = 1'b0;
		fault_gp = 1'b0;
		if (wide && direct_far) begin
			fault_ud = 1'b1;
		end
		if (!wide && opcode == op_escape && opcode2 == op2_sys_group &&
			modrm == op2_kswap_modrm) begin
			fault_ud = 1'b1;
		end
		if (long_mode && opcode == op_escape &&
			(opcode2 == op2_fast_entry || opcode2 == op2_fast_exit)) begin
			fault_ud = 1'b1;
		end
		if (long_mode && gate_access &&
			(gate_type == gate_type_task || gate_type != gate_type_call64 ||
			!gate_target_wide)) begin
			fault_gp = 1'b1;
		end
		if (long_mode && far_return &&
			(ret_stack_sel & sel_rpl_clear) == null_selector &&
			!(ret_target_wide && ret_target_priv < priv_user)) begin
			fault_gp = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid <= 1'b0;
		end else if (take) begin
			out_valid <= 1'b1;
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			op_width         <= 2'(size_32);
			addr_width       <= 2'(size_64);
			seg_sel          <= 3'(seg_none);
			eff_addr         <= 64'h0;
			imm_ext          <= 64'h0;
			is_nop           <= 1'b0;
			is_stack_op      <= 1'b0;
			is_near_branch   <= 1'b0;
			invalid_op_fault <= 1'b0;
			protect_fault    <= 1'b0;
		end else if (take) begin
			op_width         <= next_opw;
			addr_width       <= next_adw;
			seg_sel          <= next_seg;
			eff_addr         <= next_addr;
			imm_ext          <= next_imm;
			is_nop           <= nop_form && !fault_ud;
			is_stack_op      <= stack_op && wide;
			is_near_branch   <= near_br && wide;
			invalid_op_fault <= fault_ud;
			protect_fault    <= fault_gp;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			branch_target  <= 64'h0;
			load_stack_ptr <= 1'b0;
			new_stack_ptr  <= 64'h0;
			load_stack_sel <= 1'b0;
			new_stack_sel  <= 16'h0;
			push_wide      <= 1'b0;
			copy_params    <= 1'b0;
		end else if (take) begin
			branch_target  <= gate_offset;
			load_stack_ptr <= long_mode && gate_access && gate_priv_change &&
				!fault_gp;
			new_stack_ptr  <= table_stack_ptr;
			load_stack_sel <= long_mode && gate_access && gate_priv_change &&
				!fault_gp;
			new_stack_sel  <= {14'h0, gate_new_priv};
			push_wide      <= long_mode && gate_access && !fault_gp;
			copy_params    <= !long_mode && gate_access && gate_priv_change;
		end
	end

	wide_dest_merge merge (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (wb_valid),
		.in_width  (wb_width),
		.in_byte   (wb_byte),
		.in_old    (wb_old),
		.in_result (wb_result),
		.out_valid (wb_out_valid),
		.out_value (wb_out_value)
	);

endmodule

// file: test/wide_decode_chk.sv
`timescale 1ns/1ps
module wide_decode_chk
	import wide_decode_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        in_valid,
	input wire logic        in_ready,
	input wire logic [1:0]  cpu_mode,
	input wire logic [2:0]  prefix_count,
	input wire logic        ext_present,
	input wire logic [3:0]  ext_bits,
	input wire logic [7:0]  opcode,
	input wire logic [7:0]  opcode2,
	input wire logic [7:0]  modrm,
	input wire logic [63:0] disp,
	input wire logic [63:0] next_ip,
	input wire logic        gate_access,
	input wire logic [3:0]  gate_type,
	input wire logic        wb_valid,
	input wire logic        wb_byte,
	input wire logic [1:0]  wb_width,
	input wire logic [63:0] wb_old,
	input wire logic [63:0] wb_result,
	input wire logic        wb_out_valid,
	input wire logic [63:0] wb_out_value,
	input wire logic        out_ready,
	input wire logic        out_valid,
	input wire logic [1:0]  op_width,
	input wire logic [1:0]  addr_width,
	input wire logic [63:0] eff_addr,
	input wire logic        is_nop,
	input wire logic        invalid_op_fault,
	input wire logic        protect_fault,
	input wire logic        copy_params
);
	logic [63:0] rel_exp;
	logic [63:0] old_q;
	logic [63:0] res_q;

	// Expected values one cycle on
	always_ff @(posedge clk) begin
		rel_exp <= next_ip + {{32{disp[31]}}, disp[31:0]};
		old_q <= wb_old;
		res_q <= wb_result;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence take_s;
		in_valid && in_ready;
	endsequence
	sequence long_take_s;
		take_s ##0 cpu_mode != mode_legacy;
	endsequence
	sequence plain_s;
		take_s ##0 cpu_mode == mode_wide && prefix_count == 3'h0
			&& opcode == 8'h8b;
	endsequence

	ready_rule_a: assert property (in_ready == (!out_valid || out_ready))
		else $error("ready does not follow output stage");
	answer_held_a: assert property (out_valid && !out_ready
		|=> out_valid && $stable(eff_addr) && $stable(op_width))
		else $error("answer changed while stalled");
	op_default_a: assert property (plain_s ##0 !ext_present
		|=> op_width == size_32) else $error("default operand size wrong");
	op_ext_a: assert property (plain_s ##0 ext_present
		&& ext_bits[ext_w_bit] |=> op_width == size_64)
		else $error("extension width not applied");
	addr_default_a: assert property (plain_s
		|=> addr_width == size_64) else $error("default address size wrong");
	ptr_rel_a: assert property (plain_s ##0 modrm == 8'h05
		|=> eff_addr == rel_exp) else $error("pointer relative address wrong");
	zext_wb_a: assert property (wb_valid && !wb_byte
		&& wb_width == 2'h1 |=> wb_out_valid
		&& wb_out_value == {32'h0, res_q[31:0]})
		else $error("32-bit result not zero extended");
	keep_byte_a: assert property (wb_valid && wb_byte
		|=> wb_out_value == {old_q[63:8], res_q[7:0]})
		else $error("byte write lost upper bits");
	fast_fault_a: assert property (long_take_s ##0 opcode == op_escape
		&& (opcode2 == op2_fast_entry || opcode2 == op2_fast_exit)
		|=> invalid_op_fault) else $error("fast entry or exit not faulted");
	task_gate_a: assert property (long_take_s ##0 gate_access
		&& gate_type == gate_type_task |=> protect_fault)
		else $error("task gate accepted in long mode");
	no_copy_a: assert property (long_take_s ##0 gate_access
		|=> !copy_params) else $error("parameter copy in long mode");
	true_nop_a: assert property (take_s ##0 cpu_mode == mode_wide
		&& prefix_count == 3'h0 && opcode == op_nop |=> is_nop)
		else $error("opcode 90h not a no-operation");
endmodule

bind wide_mode_prefix_size_decode wide_decode_chk u_chk (.*);

// file: test/wide_pipe_model.sv
`timescale 1ns/1ps
module wide_pipe_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic slow,
	input  wire logic out_valid,
	output logic      out_ready,
	output logic [7:0] n_taken
);
	logic [1:0] gap;

	// Accepts every cycle, or one in three when slow
	always_ff @(posedge clk) begin
		if (rst) begin
			gap <= 2'h0;
			out_ready <= 1'b0;
			n_taken <= 8'h00;
		end else begin
			gap <= (gap == 2'h2) ? 2'h0 : gap + 2'h1;
			out_ready <= !slow || gap == 2'h1;
			if (out_valid && out_ready)
				n_taken <= n_taken + 8'h01;
		end
	end
endmodule

// file: test/wide_mode_prefix_size_decode_bench.sv
`timescale 1ns/1ps
module wide_mode_prefix_size_decode_bench
	import wide_decode_pkg::*;
;
	logic        clk, rst, in_valid, in_ready, legacy_op32, legacy_addr32;
	logic        ext_present, gate_access, far_return, gate_target_wide;
	logic        gate_priv_change, ret_target_wide, wb_valid, wb_byte, slow;
	logic        wb_out_valid, out_ready, out_valid, is_nop, is_stack_op;
	logic        is_near_branch, invalid_op_fault, protect_fault;
	logic        load_stack_ptr, load_stack_sel, push_wide, copy_params;
	logic [1:0]  cpu_mode, cur_priv, gate_new_priv, ret_target_priv, wb_width;
	logic [1:0]  op_width, addr_width;
	logic [2:0]  prefix_count, seg_sel;
	logic [3:0]  ext_bits, gate_type;
	logic [7:0]  opcode, opcode2, modrm, n_taken;
	logic [15:0] ret_stack_sel, new_stack_sel;
	logic [31:0] prefix_bytes;
	logic [63:0] disp, imm, next_ip, base_value, index_value, seg_one_base;
	logic [63:0] seg_two_base, gate_offset, table_stack_ptr, wb_old, wb_result;
	logic [63:0] wb_out_value, eff_addr, imm_ext, branch_target, new_stack_ptr;
	logic [63:0] wexp [4];
	int          n_fail, total_checks, n_go, i, k;
	logic [41:0] rows [$];

	wide_mode_prefix_size_decode DUT (.*);
	wide_pipe_model far_end (.clk(clk), .rst(rst), .slow(slow),
		.out_valid(out_valid), .out_ready(out_ready), .n_taken(n_taken));

	always #2 clk = ~clk;

	task conclude();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task check(logic [255:0] seen, logic [255:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t got %0h want %0h", $time, seen, exp);
		end
	endtask

	task r(logic [1:0] m, logic [7:0] p, logic [4:0] x, logic [7:0] o, o2,
		logic [1:0] w, a, logic [2:0] s, logic [3:0] f);
		rows.push_back({m, p, x, o, o2, w, a, s, f});
	endtask

	task set(logic [1:0] m, logic [7:0] p, logic [4:0] x, logic [7:0] o,
		logic [7:0] o2, logic [7:0] mr);
		cpu_mode <= m;
		prefix_bytes <= {24'h0, p};
		prefix_count <= {2'h0, p != 8'h00};
		ext_present <= x[4];
		ext_bits <= x[3:0];
		opcode <= o;
		opcode2 <= o2;
		modrm <= mr;
	endtask

	// One decode transfer, bounded waits on both handshakes
	task go();
		in_valid <= 1'b1;
		n_go++;
		k = 0;
		do begin @(negedge clk); k++; end while (!in_ready && k < 50);
		@(posedge clk);
		in_valid <= 1'b0;
		do begin @(negedge clk); k++; end while (!out_valid && k < 50);
		if (k >= 50) begin
			n_fail++;
			conclude();
		end
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{in_valid, ext_present, gate_access, far_return, wb_valid} = '0;
		{gate_target_wide, gate_priv_change, ret_target_wide, wb_byte} = '0;
		{cpu_mode, gate_new_priv, ret_target_priv, wb_width, gate_type} = '0;
		{prefix_count, ext_bits, opcode, opcode2, modrm, ret_stack_sel} = '0;
		{prefix_bytes, disp, imm, next_ip, base_value, seg_one_base} = '0;
		{seg_two_base, gate_offset, table_stack_ptr, wb_old, wb_result} = '0;
		{legacy_op32, legacy_addr32, slow, cur_priv, index_value} = '0;
		legacy_op32 = 1'b1;
		legacy_addr32 = 1'b1;
		{n_fail, total_checks, n_go} = '0;
		r(2'h2, 8'h00, 5'h00, 8'h8b, 8'h00, 2'h1, 2'h2, 3'h0, 4'h0);
		r(2'h2, 8'h66, 5'h00, 8'h8b, 8'h00, 2'h0, 2'h2, 3'h0, 4'h0);
		r(2'h2, 8'h66, 5'h18, 8'h8b, 8'h00, 2'h2, 2'h2, 3'h0, 4'h0);
		r(2'h2, 8'h00, 5'h18, 8'h8b, 8'h00, 2'h2, 2'h2, 3'h0, 4'h0);
		r(2'h2, 8'h67, 5'h00, 8'h8b, 8'h00, 2'h1, 2'h1, 3'h0, 4'h0);
		r(2'h2, 8'h00, 5'h10, 8'h8b, 8'h00, 2'h1, 2'h2, 3'h0, 4'h0);
		r(2'h2, 8'h2e, 5'h00, 8'h8b, 8'h00, 2'h1, 2'h2, 3'h0, 4'h0);
		r(2'h2, 8'h36, 5'h00, 8'h8b, 8'h00, 2'h1, 2'h2, 3'h0, 4'h0);
		r(2'h2, 8'h3e, 5'h00, 8'h8b, 8'h00, 2'h1, 2'h2, 3'h0, 4'h0);
		r(2'h2, 8'h26, 5'h00, 8'h8b, 8'h00, 2'h1, 2'h2, 3'h0, 4'h0);
		r(2'h2, 8'h64, 5'h00, 8'h8b, 8'h00, 2'h1, 2'h2, 3'h1, 4'h0);
		r(2'h2, 8'h65, 5'h00, 8'h8b, 8'h00, 2'h1, 2'h2, 3'h2, 4'h0);
		r(2'h2, 8'h00, 5'h00, 8'h50, 8'h00, 2'h2, 2'h2, 3'h0, 4'h4);
		r(2'h2, 8'h66, 5'h00, 8'h50, 8'h00, 2'h0, 2'h2, 3'h0, 4'h4);
		r(2'h2, 8'h66, 5'h18, 8'h50, 8'h00, 2'h2, 2'h2, 3'h0, 4'h4);
		r(2'h2, 8'h00, 5'h00, 8'hc8, 8'h00, 2'h2, 2'h2, 3'h0, 4'h4);
		r(2'h2, 8'h00, 5'h00, 8'h9c, 8'h00, 2'h2, 2'h2, 3'h0, 4'h4);
		r(2'h2, 8'h00, 5'h00, 8'h0f, 8'ha0, 2'h2, 2'h2, 3'h0, 4'h4);
		r(2'h2, 8'h00, 5'h00, 8'he8, 8'h00, 2'h2, 2'h2, 3'h0, 4'h2);
		r(2'h2, 8'h66, 5'h00, 8'he8, 8'h00, 2'h0, 2'h2, 3'h0, 4'h2);
		r(2'h2, 8'h67, 5'h00, 8'hc3, 8'h00, 2'h2, 2'h1, 3'h0, 4'h2);
		r(2'h2, 8'h00, 5'h00, 8'h9a, 8'h00, 2'h1, 2'h2, 3'h0, 4'h1);
		r(2'h2, 8'h00, 5'h00, 8'hea, 8'h00, 2'h1, 2'h2, 3'h0, 4'h1);
		r(2'h2, 8'h00, 5'h00, 8'h0f, 8'h01, 2'h1, 2'h2, 3'h0, 4'h0);
		r(2'h1, 8'h00, 5'h00, 8'h0f, 8'h01, 2'h1, 2'h1, 3'h0, 4'h1);
		r(2'h0, 8'h00, 5'h00, 8'h0f, 8'h01, 2'h1, 2'h1, 3'h0, 4'h1);
		r(2'h2, 8'h00, 5'h00, 8'h0f, 8'h34, 2'h1, 2'h2, 3'h0, 4'h1);
		r(2'h1, 8'h00, 5'h00, 8'h0f, 8'h35, 2'h1, 2'h1, 3'h0, 4'h1);
		r(2'h0, 8'h00, 5'h00, 8'h0f, 8'h34, 2'h1, 2'h1, 3'h0, 4'h0);
		r(2'h2, 8'h00, 5'h18, 8'h90, 8'h00, 2'h2, 2'h2, 3'h0, 4'h8);
		r(2'h2, 8'h00, 5'h00, 8'h87, 8'h00, 2'h1, 2'h2, 3'h0, 4'h0);
		r(2'h1, 8'h66, 5'h00, 8'h8b, 8'h00, 2'h0, 2'h1, 3'h0, 4'h0);
		r(2'h1, 8'h2e, 5'h00, 8'h8b, 8'h00, 2'h1, 2'h1, 3'h3, 4'h0);
		r(2'h1, 8'h00, 5'h18, 8'h8b, 8'h00, 2'h1, 2'h1, 3'h0, 4'h0);
		r(2'h0, 8'h67, 5'h00, 8'h8b, 8'h00, 2'h1, 2'h0, 3'h0, 4'h0);
		wexp = '{64'hffee_ddcc_bbaa_9977, 64'hffee_ddcc_bbaa_7777,
			64'h0000_0000_5566_7777, 64'h1122_3344_5566_7777};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check({out_valid, op_width, addr_width, in_ready, wb_out_valid},
			{1'b0, 2'h1, 2'h2, 1'b1, 1'b0});
		$display("reset done");
		foreach (rows[j]) begin
			@(posedge clk);
			slow <= j[0];
			set(rows[j][41:40], rows[j][39:32], rows[j][31:27],
				rows[j][26:19], rows[j][18:11],
				(rows[j][26:11] == 16'h0f01) ? op2_kswap_modrm : 8'hc0);
			go();
			check({op_width, addr_width, seg_sel,
				is_nop, is_stack_op, is_near_branch,
				invalid_op_fault}, rows[j][10:0]);
			$display("row %0d done", j);
		end
		@(posedge clk);
		set(2'h2, 8'h00, 5'h00, 8'h8b, 8'h00, 8'h05);
		disp <= 64'h0000_0000_8000_0010;
		next_ip <= 64'h1000_0000_0000_0000;
		go();
		check(eff_addr, 64'h0fff_ffff_8000_0010);
		@(posedge clk);
		set(2'h2, 8'h67, 5'h00, 8'h8b, 8'h00, 8'h80);
		base_value <= 64'h0000_0001_ffff_fff0;
		disp <= 64'h0000_0000_0000_0020;
		go();
		check(eff_addr, 64'h0000_0000_0000_0010);
		@(posedge clk);
		set(2'h2, 8'h65, 5'h00, 8'h8b, 8'h00, 8'h80);
		base_value <= 64'h0000_0000_0000_0100;
		disp <= 64'h0000_0000_0000_0004;
		seg_two_base <= 64'h2000_0000_0000_0000;
		go();
		check(eff_addr, 64'h2000_0000_0000_0104);
		@(posedge clk);
		set(2'h2, 8'h00, 5'h18, 8'hb8, 8'h00, 8'hc0);
		imm <= 64'h1234_5678_9abc_def0;
		go();
		check(imm_ext, 64'h1234_5678_9abc_def0);
		@(posedge clk);
		set(2'h2, 8'h00, 5'h00, 8'h81, 8'h00, 8'hc0);
		imm <= 64'h0000_0000_8000_0000;
		go();
		check(imm_ext, 64'hffff_ffff_8000_0000);
		$display("address and immediate done");
		@(posedge clk);
		set(2'h2, 8'h00, 5'h00, 8'hff, 8'h00, 8'h18);
		{gate_access, gate_target_wide, gate_priv_change} <= 3'h7;
		gate_type <= gate_type_call64;
		gate_new_priv <= 2'h2;
		gate_offset <= 64'h7fff_0000_1234_5678;
		table_stack_ptr <= 64'h0000_7fff_ffff_e000;
		go();
		check({branch_target, new_stack_ptr, new_stack_sel, load_stack_ptr,
			load_stack_sel, push_wide, copy_params, protect_fault},
			{64'h7fff_0000_1234_5678, 64'h0000_7fff_ffff_e000, 16'h0002,
			5'h1c});
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			gate_type <= (i == 0) ? gate_type_task : gate_type_call64;
			gate_target_wide <= (i == 0);
			go();
			check(protect_fault, 1'b1);
		end
		for (i = 0; i < 3; i++) begin
			@(posedge clk);
			set(2'h2, 8'h00, 5'h00, 8'hcb, 8'h00, 8'hc0);
			{gate_access, far_return} <= 2'h1;
			ret_stack_sel <= 16'h0002;
			ret_target_wide <= (i < 2);
			ret_target_priv <= (i == 1) ? 2'h3 : 2'h2;
			go();
			check(protect_fault, (i != 0));
		end
		$display("far transfer done");
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			wb_valid <= 1'b1;
			wb_byte <= (i == 0);
			wb_width <= (i == 0) ? 2'h0 : 2'(i - 1);
			wb_old <= 64'hffee_ddcc_bbaa_9988;
			wb_result <= 64'h1122_3344_5566_7777;
			@(posedge clk);
			wb_valid <= 1'b0;
			@(negedge clk);
			check({wb_out_valid, wb_out_value}, {1'b1, wexp[i]});
		end
		@(negedge clk);
		check(wb_out_valid, 1'b0);
		$display("writeback done");
		@(posedge clk);
		slow <= 1'b0;
		repeat (4) @(posedge clk);
		check(n_taken, n_go[7:0]);
		conclude();
	end
endmodule
